/* File: ces_bus_node.sv */
// Model of the protocol engine and bus nodes that feed the block
// Assumes the bench calls its tasks just after a clock edge
`timescale 1ns/1ps
`default_nettype none

module ces_bus_node (
  // Clock
  input  wire logic clk_sys_i,
  // Reported errors
  output logic       err_event_o,
  output logic [2:0] err_code_o,
  // Bit monitor
  output logic       bit_chk_o,
  output logic       drv_lvl_o,
  output logic       smp_lvl_o,
  output logic       arb_fld_o,
  // Counting pulses, tx_err at bit 0
  output logic [5:0] cnt_ev_o,
  // Other interrupt sources
  output logic [5:0] irq_ev_o
);
  // ********************************************************
  // Stimulus tasks
  // ********************************************************
  initial begin
    {err_event_o, err_code_o, bit_chk_o, drv_lvl_o} = 6'h00;
    {smp_lvl_o, arb_fld_o, cnt_ev_o, irq_ev_o} = 14'h0000;
  end

  // Released lines flip so a stale value cannot pass
  task automatic err(input logic [2:0] code);
    @(posedge clk_sys_i);
    err_event_o <= 1'b1;
    err_code_o  <= code;
    @(posedge clk_sys_i);
    err_event_o <= 1'b0;
    err_code_o  <= ~code;
  endtask

  task automatic bit_cmp(input logic drv, input logic smp, input logic arb);
    @(posedge clk_sys_i);
    {bit_chk_o, drv_lvl_o, smp_lvl_o, arb_fld_o} <= {1'b1, drv, smp, arb};
    @(posedge clk_sys_i);
    {bit_chk_o, drv_lvl_o, smp_lvl_o, arb_fld_o} <= {1'b0, ~drv, ~smp, ~arb};
  endtask

  task automatic ev(input int idx, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_i);
      cnt_ev_o <= 6'h01 << idx;
      @(posedge clk_sys_i);
      cnt_ev_o <= 6'h00;
    end
  endtask

  task automatic irq(input logic [5:0] bits);
    @(posedge clk_sys_i);
    irq_ev_o <= bits;
    @(posedge clk_sys_i);
    irq_ev_o <= 6'h00;
  endtask
endmodule
`default_nettype wire

/* File: ces_err_cnt.sv */
// Transmit and receive error counters with fault confinement
// Assumes one-cycle event pulses on the system clock
`timescale 1ns/1ps
`default_nettype none
`include "ces_regs.svh"

module ces_err_cnt (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  // Events
  input  wire logic       clr_i,
  input  wire logic       bus_off_flag_rec_i,
  input  wire logic       tx_err_i,
  input  wire logic       tx_ok_i,
  input  wire logic       rx_err_i,
  input  wire logic       rx_prim_i,
  input  wire logic       rx_ok_i,
  // Counts
  output logic [8:0]      tec_o,
  output logic [7:0]      rec_o
);

  ces_pkg::ces_cnt_t q;
  ces_pkg::ces_cnt_t d;

  // ********************************************************
  // Counting
  // ********************************************************
  always_comb begin
    logic [9:0] r;
    d = q;
    r = {2'h0, q.rx_error_count};
    if (q.tx_error_count < `CES_LVL_BUS_OFF_FLAG) begin
      if (tx_err_i) begin
        d.tx_error_count = q.tx_error_count + `CES_TX_ERR_INC;
      end else if (tx_ok_i && q.tx_error_count != `CES_RST_TEC) begin
        d.tx_error_count = q.tx_error_count - 9'h001;
      end
      // Saturate at bus-off so the flag cannot wrap away
      if (d.tx_error_count > `CES_LVL_BUS_OFF_FLAG) begin
        d.tx_error_count = `CES_LVL_BUS_OFF_FLAG;
      end
    end
    if (rx_ok_i) begin
      if ({1'b0, q.rx_error_count} >= `CES_LVL_PASV) begin
        r = {2'h0, `CES_REC_OK_SET};
      end else if (q.rx_error_count != `CES_RST_REC) begin
        r = r - 10'h001;
      end
    end else begin
      if (rx_err_i) begin
        r = r + 10'h001;
      end
      if (rx_prim_i) begin
        r = r + {2'h0, `CES_RX_PRIM_INC};
      end
    end
    d.rx_error_count = (r > {2'h0, `CES_RX_MAX}) ? `CES_RX_MAX : r[7:0];
    if (clr_i || bus_off_flag_rec_i) begin
      d.tx_error_count = `CES_RST_TEC;
      d.rx_error_count = `CES_RST_REC;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      q <= '{tx_error_count: `CES_RST_TEC, rx_error_count: `CES_RST_REC};
    end else begin
      q <= d;
    end
  end

  assign tec_o = q.tx_error_count;
  assign rec_o = q.rx_error_count;

  // ********************************************************
  // Checks
  // ********************************************************
  property p_tx_inc;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (tx_err_i && !clr_i && !bus_off_flag_rec_i && tec_o < 9'h0F8)
      |=> tec_o == $past(tec_o) + 9'h008;
  endproperty
  a_tx_inc: assert property (p_tx_inc)
    else $error("tx error count did not rise by eight");

endmodule
`default_nettype wire

/* File: ces_pkg.sv */
// Types shared by the error status block and its counters
// Assumes ces_regs.svh on the include path
`include "ces_regs.svh"

package ces_pkg;

  // ********************************************************
  // Error codes and state
  // ********************************************************
  typedef enum logic [2:0] {
    CES_LEC_NONE  = 3'h0,
    CES_LEC_STUFF = 3'h1,
    CES_LEC_FORM  = 3'h2,
    CES_LEC_ACK   = 3'h3,
    CES_LEC_BREC  = 3'h4,
    CES_LEC_BDOM  = 3'h5,
    CES_LEC_CRC   = 3'h6,
    CES_LEC_UNDEF = 3'h7
  } ces_lec_t;

  typedef struct packed {
    logic [8:0] tx_error_count;
    logic [7:0] rx_error_count;
  } ces_cnt_t;

  typedef struct packed {
    logic [2:0]  last_error_code;
    logic [5:0]  ie;
    logic [5:0]  pend;
    logic        cclr;
    logic [4:0]  lvl_prev;
    logic [15:0] rdata;
  } ces_core_t;

endpackage

/* File: ces_regs.svh */
// Register offsets, field positions, reset values and limits
// Assumes byte addresses on a 16-bit address port
`ifndef CES_REGS_SVH
`define CES_REGS_SVH

// ********************************************************
// Register offsets
// ********************************************************
`define CES_ADDR_LEC       16'hFF92
`define CES_ADDR_INFO      16'hFF93
`define CES_ADDR_ERC       16'hFF94
`define CES_ADDR_IE        16'hFF96
`define CES_ADDR_INTS      16'hFF98
`define CES_ADDR_CTRL      16'hFF9A

// ********************************************************
// Reset values
// ********************************************************
`define CES_RST_LEC        3'h0
`define CES_RST_IE         6'h00
`define CES_RST_INTS       6'h00
`define CES_RST_TEC        9'h000
`define CES_RST_REC        8'h00

// ********************************************************
// Field positions
// ********************************************************
`define CES_IE_SET_LSB     8
`define CES_CTRL_CCLR_BIT  0
`define CES_INFO_BUS_OFF_FLAG_BIT  4
`define CES_ERC_PASV_BIT   15
`define CES_IRQ_PROTO_BIT  3
`define CES_IRQ_STATE_BIT  2

// ********************************************************
// Codes and counting limits
// ********************************************************
`define CES_LEC_BIT_REC    3'h4
`define CES_LEC_BIT_DOM    3'h5
`define CES_LVL_WARN       9'h060
`define CES_LVL_PASV       9'h080
`define CES_LVL_BUS_OFF_FLAG       9'h100
`define CES_TX_ERR_INC     9'h008
`define CES_RX_PRIM_INC    8'h08
`define CES_RX_MAX         8'hFF
`define CES_REC_OK_SET     8'h77

`endif

/* File: ces_top.sv */
// Error reporting and interrupt enable block of a CAN controller
// Assumes protocol engine events are one-cycle pulses on clk_sys_i
//
// Behaviour
// - Three-bit code reports latest protocol error
// - Recessive driven, dominant seen outside arbitration: code four
// - Dominant driven, recessive seen: code five
// - Entering initialization keeps the error code
// - Writes with a nonzero low byte to code register ignored
// - Bus-off flag set at count 256+
// - Transmit level field: 00, 01, 11
// - Receive level field: 00, 01, 11
// - Counter register packs tx and rx counts
// - Counts follow CAN fault confinement rules
// - Bit 15 marks receive error passive
// - Receive count invalid while level is 11
// - Transmit count invalid during bus-off
// - Enable bit gates its pending bit onto the interrupt output
// - Enable register uses set/clear bit pairs
// - Counter clear in init clears counts, self-clears
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ces_regs.svh"

module ces_top (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  // Register port
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o,
  // Protocol engine: reported errors
  input  wire logic        err_event_i,
  input  wire logic [2:0]  err_code_i,
  // Protocol engine: bit monitor
  input  wire logic        bit_chk_i,
  input  wire logic        drv_lvl_i,
  input  wire logic        smp_lvl_i,
  input  wire logic        arb_fld_i,
  // Protocol engine: counting events
  input  wire logic        tx_err_i,
  input  wire logic        tx_ok_i,
  input  wire logic        rx_err_i,
  input  wire logic        rx_prim_i,
  input  wire logic        rx_ok_i,
  input  wire logic        bus_off_flag_rec_i,
  // Mode and other interrupt sources
  input  wire logic        init_mode_i,
  input  wire logic [5:0]  irq_event_i,
  // Interrupt
  output logic             irq_o
);

  ces_pkg::ces_core_t q;
  ces_pkg::ces_core_t d;

  logic [8:0] tec_w;
  logic [7:0] rec_w;
  logic [1:0] tx_lvl_w;
  logic [1:0] rx_lvl_w;
  logic       bus_off_flag_w;
  logic       pasv_w;
  logic [4:0] lvl_now_w;
  logic [7:0] info_w;
  logic [15:0] erc_w;
  logic       bit_rec_w;
  logic       bit_dom_w;
  logic       proto_w;

  // ********************************************************
  // Level decoding
  // ********************************************************
  // Encoding 10 never appears
  function automatic logic [1:0] err_level(input logic [8:0] cnt);
    if (cnt < `CES_LVL_WARN) begin
      err_level = 2'h0;
    end else if (cnt < `CES_LVL_PASV) begin
      err_level = 2'h1;
    end else begin
      err_level = 2'h3;
    end
  endfunction

  // ********************************************************
  // Error counters
  // ********************************************************
  ces_err_cnt u_cnt (
    .clk_sys_i  (clk_sys_i),
    .rstn_i     (rstn_i),
    .clr_i      (q.cclr),
    .bus_off_flag_rec_i (bus_off_flag_rec_i),
    .tx_err_i   (tx_err_i),
    .tx_ok_i    (tx_ok_i),
    .rx_err_i   (rx_err_i),
    .rx_prim_i  (rx_prim_i),
    .rx_ok_i    (rx_ok_i),
    .tec_o      (tec_w),
    .rec_o      (rec_w)
  );

  assign bus_off_flag_w    = tec_w >= `CES_LVL_BUS_OFF_FLAG;
  assign tx_lvl_w  = err_level(tec_w);
  assign rx_lvl_w  = err_level({1'b0, rec_w});
  assign pasv_w    = {1'b0, rec_w} >= `CES_LVL_PASV;
  assign lvl_now_w = {bus_off_flag_w, tx_lvl_w, rx_lvl_w};
  assign info_w    = {3'h0, lvl_now_w};
  // Count fields carry raw low bits; invalid in passive or bus-off
  assign erc_w     = {pasv_w, rec_w[6:0], tec_w[7:0]};

  // ********************************************************
  // Bit monitor: recessive is 1, dominant is 0
  // ********************************************************
  assign bit_rec_w = bit_chk_i && drv_lvl_i && !smp_lvl_i
                     && !arb_fld_i;
  assign bit_dom_w = bit_chk_i && !drv_lvl_i && smp_lvl_i;
  assign proto_w   = err_event_i || bit_rec_w || bit_dom_w;

  // ********************************************************
  // Register and state update
  // ********************************************************
  always_comb begin
    logic       set_b;
    logic       clr_b;
    logic [5:0] evt;
    d       = q;
    set_b   = 1'b0;
    clr_b   = 1'b0;
    evt     = irq_event_i;
    d.rdata = 16'h0000;

    // Bus write; new error below still wins over a clear
    if (wr_i) begin
      if (addr_i == `CES_ADDR_LEC) begin
        if (wdata_i[7:0] == 8'h00) begin
          d.last_error_code = `CES_RST_LEC;
        end
      end else if (addr_i == `CES_ADDR_IE) begin
        // Bits 15,14,7,6 are assumed zero and not decoded
        for (int n = 0; n < 6; n++) begin
          set_b = wdata_i[n + `CES_IE_SET_LSB];
          clr_b = wdata_i[n];
          if (set_b && !clr_b) begin
            d.ie[n] = 1'b1;
          end else if (!set_b && clr_b) begin
            d.ie[n] = 1'b0;
          end
        end
      end else if (addr_i == `CES_ADDR_INTS) begin
        d.pend = q.pend & ~wdata_i[5:0];
      end else if (addr_i == `CES_ADDR_CTRL) begin
        if (wdata_i[`CES_CTRL_CCLR_BIT] && init_mode_i) begin
          d.cclr = 1'b1;
        end
      end
    end

    // Clear pulse lasts one cycle, then the bit drops itself
    if (q.cclr) begin
      d.cclr = 1'b0;
    end

    // Latest error always overwrites; mode changes never touch it
    if (err_event_i) begin
      d.last_error_code = err_code_i;
    end else if (bit_rec_w) begin
      d.last_error_code = `CES_LEC_BIT_REC;
    end else if (bit_dom_w) begin
      d.last_error_code = `CES_LEC_BIT_DOM;
    end

    // Sticky sources; set wins over a same-cycle clear
    evt[`CES_IRQ_PROTO_BIT] = evt[`CES_IRQ_PROTO_BIT] | proto_w;
    evt[`CES_IRQ_STATE_BIT] = evt[`CES_IRQ_STATE_BIT]
                              | (lvl_now_w != q.lvl_prev);
    d.pend     = d.pend | evt;
    d.lvl_prev = lvl_now_w;

    // Bus read, answered one cycle later
    if (rd_i) begin
      if (addr_i == `CES_ADDR_LEC) begin
        d.rdata = {13'h0000, q.last_error_code};
      end else if (addr_i == `CES_ADDR_INFO) begin
        d.rdata = {8'h00, info_w};
      end else if (addr_i == `CES_ADDR_ERC) begin
        d.rdata = erc_w;
      end else if (addr_i == `CES_ADDR_IE) begin
        d.rdata = {10'h000, q.ie};
      end else if (addr_i == `CES_ADDR_INTS) begin
        d.rdata = {10'h000, q.pend};
      end else if (addr_i == `CES_ADDR_CTRL) begin
        d.rdata = {15'h0000, q.cclr};
      end else begin
        d.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      q <= '{last_error_code:      `CES_RST_LEC,
             ie:       `CES_RST_IE,
             pend:     `CES_RST_INTS,
             cclr:     1'b0,
             lvl_prev: 5'h00,
             rdata:    16'h0000};
    end else begin
      q <= d;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign rdata_o = q.rdata;
  assign irq_o   = |(q.pend & q.ie);

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_rd(logic [15:0] a);
    rd_i && addr_i == a;
  endsequence

  property p_lec_event;
    err_event_i |=> q.last_error_code == $past(err_code_i);
  endproperty
  a_lec_event: assert property (p_lec_event)
    else $error("error code not recorded");

  property p_bit_rec;
    (bit_chk_i && drv_lvl_i && !smp_lvl_i && !arb_fld_i && !err_event_i)
      |=> q.last_error_code == 3'h4;
  endproperty
  a_bit_rec: assert property (p_bit_rec)
    else $error("recessive bit error not coded four");

  property p_bit_dom;
    (bit_chk_i && !drv_lvl_i && smp_lvl_i && !err_event_i)
      |=> q.last_error_code == 3'h5;
  endproperty
  a_bit_dom: assert property (p_bit_dom)
    else $error("dominant bit error not coded five");

  // Recessive driven, dominant seen inside arbitration is a lost contest, not an error
  property p_bit_arb;
    (bit_chk_i && drv_lvl_i && !smp_lvl_i && arb_fld_i && !err_event_i
      && !wr_i) |=> $stable(q.last_error_code);
  endproperty
  a_bit_arb: assert property (p_bit_arb)
    else $error("arbitration mismatch changed error code");

  property p_init_keep;
    ($rose(init_mode_i) && !proto_w && !wr_i) |=> $stable(q.last_error_code);
  endproperty
  a_init_keep: assert property (p_init_keep)
    else $error("error code changed on entering init");

  property p_lec_nowr;
    (wr_i && addr_i == `CES_ADDR_LEC && wdata_i[7:0] != 8'h00
      && !proto_w) |=> $stable(q.last_error_code);
  endproperty
  a_lec_nowr: assert property (p_lec_nowr)
    else $error("nonzero write changed error code");

  property p_bus_off_flag_rd;
    s_rd(`CES_ADDR_INFO) |=> rdata_o[4] == ($past(tec_w) > 9'h0FF);
  endproperty
  a_bus_off_flag_rd: assert property (p_bus_off_flag_rd)
    else $error("bus-off flag wrong");

  property p_tx_lvl;
    s_rd(`CES_ADDR_INFO) |=> rdata_o[3:2] ==
      (($past(tec_w) < 9'h060) ? 2'h0 :
       ($past(tec_w) < 9'h080) ? 2'h1 : 2'h3);
  endproperty
  a_tx_lvl: assert property (p_tx_lvl)
    else $error("transmit level field wrong");

  property p_rx_lvl;
    s_rd(`CES_ADDR_INFO) |=> rdata_o[1:0] ==
      (($past(rec_w) < 8'h60) ? 2'h0 :
       ($past(rec_w) < 8'h80) ? 2'h1 : 2'h3);
  endproperty
  a_rx_lvl: assert property (p_rx_lvl)
    else $error("receive level field wrong");

  property p_erc_rd;
    s_rd(`CES_ADDR_ERC) |=> rdata_o ==
      {$past(rec_w) > 8'h7F, $past(rec_w[6:0]), $past(tec_w[7:0])};
  endproperty
  a_erc_rd: assert property (p_erc_rd)
    else $error("counter register read wrong");

  property p_ie_wr;
    (wr_i && addr_i == `CES_ADDR_IE && wdata_i[8] && !wdata_i[0])
      |=> q.ie[0] ##1 1'b1;
  endproperty
  a_ie_wr: assert property (p_ie_wr)
    else $error("enable bit not set");

  property p_ie_clr;
    (wr_i && addr_i == `CES_ADDR_IE && !wdata_i[8] && wdata_i[0])
      |=> !q.ie[0];
  endproperty
  a_ie_clr: assert property (p_ie_clr)
    else $error("enable bit not cleared");

  // Equal set and clear bits leave the enable alone
  property p_ie_keep;
    (wr_i && addr_i == `CES_ADDR_IE && wdata_i[8] == wdata_i[0])
      |=> q.ie[0] == $past(q.ie[0]);
  endproperty
  a_ie_keep: assert property (p_ie_keep)
    else $error("enable bit changed without request");

  property p_irq;
    (irq_event_i[0] && q.ie[0] && !(wr_i && addr_i == `CES_ADDR_IE))
      |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled pending event gave no interrupt");

  sequence s_cclr_req;
    wr_i && addr_i == `CES_ADDR_CTRL && wdata_i[0] && init_mode_i;
  endsequence
  sequence s_cclr_done;
    q.cclr ##1 (!q.cclr && tec_w == 9'h000 && rec_w == 8'h00);
  endsequence
  property p_cclr;
    s_cclr_req |=> s_cclr_done;
  endproperty
  a_cclr: assert property (p_cclr)
    else $error("counter clear did not complete");

  // Outside initialization the clear request is refused
  property p_cclr_refuse;
    (wr_i && addr_i == `CES_ADDR_CTRL && !init_mode_i && !q.cclr)
      |=> !q.cclr;
  endproperty
  a_cclr_refuse: assert property (p_cclr_refuse)
    else $error("counter clear accepted outside init");

endmodule
`default_nettype wire

/* File: ces_top_test.sv */
// Self-checking bench of the error status and interrupt enable block
// Assumes ces_top, ces_bus_node and ces_regs.svh are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "ces_regs.svh"

module ces_top_test;
  // ********************************************************
  // Signals
  // ********************************************************
  logic        clk_sys_i, rstn_i, wr, rd, irq, init_mode;
  logic [15:0] addr, wdata, rdata, w;
  logic        err_ev, bit_chk, drv, smp, arb;
  logic [2:0]  err_code;
  logic [5:0]  cnt_ev, irq_ev, ie;
  logic [7:0]  seed;
  logic        rd_seen = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  int          errors, compares, tx_error_count, rx_error_count;
  logic [15:0] ra [6] = '{`CES_ADDR_LEC, `CES_ADDR_INFO, `CES_ADDR_ERC,
                          `CES_ADDR_IE, 16'hFF95, 16'h0100};
  logic [2:0]  codes [5] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7};

  ces_top ces_top_inst (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .err_event_i(err_ev), .err_code_i(err_code), .bit_chk_i(bit_chk),
    .drv_lvl_i(drv), .smp_lvl_i(smp), .arb_fld_i(arb),
    .tx_err_i(cnt_ev[0]), .tx_ok_i(cnt_ev[1]), .rx_err_i(cnt_ev[2]),
    .rx_prim_i(cnt_ev[3]), .rx_ok_i(cnt_ev[4]), .bus_off_flag_rec_i(cnt_ev[5]),
    .init_mode_i(init_mode), .irq_event_i(irq_ev), .irq_o(irq));

  ces_bus_node ces_bus_node_inst (
    .clk_sys_i(clk_sys_i), .err_event_o(err_ev), .err_code_o(err_code),
    .bit_chk_o(bit_chk), .drv_lvl_o(drv), .smp_lvl_o(smp),
    .arb_fld_o(arb), .cnt_ev_o(cnt_ev), .irq_ev_o(irq_ev));

  // ********************************************************
  // Helpers
  // ********************************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [1:0] lvl(input int v);
    return (v >= 128) ? 2'h3 : ((v >= 96) ? 2'h1 : 2'h0);
  endfunction

  task automatic wr16(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask

  // Masked bits are ones the block may leave invalid
  task automatic rd16(input logic [15:0] a, input logic [15:0] e,
                      input logic [15:0] m);
    @(posedge clk_sys_i);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clk_sys_i);
    rd <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys_i) begin
    rd_seen <= rd;
    if (rd_seen === 1'b1) begin
      compares++;
      if ((rdata & msk_q[0]) !== exp_q[0]) begin
        errors++;
        $display("BAD %0t read %h want %h", $time, rdata, exp_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  task automatic chk_irq(input logic e);
    repeat (2) @(posedge clk_sys_i);
    #1;
    compares++;
    if (irq !== e) begin
      errors++;
      $display("BAD %0t irq %b want %b", $time, irq, e);
    end
  endtask

  task automatic cnt(input int idx, input int n);
    ces_bus_node_inst.ev(idx, n);
    for (int i = 0; i < n; i++) begin
      case (idx)
        0: if (tx_error_count < 256) tx_error_count = (tx_error_count > 248) ? 256 : tx_error_count + 8;
        1: if (tx_error_count > 0 && tx_error_count < 256) tx_error_count--;
        2: rx_error_count = (rx_error_count > 254) ? 255 : rx_error_count + 1;
        3: rx_error_count = (rx_error_count > 247) ? 255 : rx_error_count + 8;
        4: rx_error_count = (rx_error_count > 127) ? 119 : ((rx_error_count > 0) ? rx_error_count - 1 : 0);
        default: {tx_error_count, rx_error_count} = 64'h0;
      endcase
    end
  endtask

  task automatic chk_cnt();
    logic [15:0] m;
    m = 16'hFFFF;
    if (rx_error_count >= 128) m[14:8] = 7'h00;
    if (tx_error_count >= 256) m[7:0] = 8'h00;
    rd16(`CES_ADDR_INFO, {11'h000, tx_error_count >= 256, lvl(tx_error_count), lvl(rx_error_count)},
         16'hFFFF);
    rd16(`CES_ADDR_ERC, {rx_error_count >= 128, rx_error_count[6:0], tx_error_count[7:0]}, m);
  endtask

  task automatic give_verdict();
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run is several hundred cycles
  initial begin
    #100000;
    errors++;
    give_verdict();
  end

  // ********************************************************
  // Scenarios
  // ********************************************************
  initial begin
    {rstn_i, wr, rd, init_mode, addr, wdata} = 36'h0;
    {errors, compares, tx_error_count, rx_error_count, seed, ie} = {128'h0, 8'h62, 6'h00};
    repeat (10) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    foreach (ra[i]) rd16(ra[i], 16'h0000, 16'hFFFF);
    foreach (codes[i]) begin
      ces_bus_node_inst.err(codes[i]);
      rd16(`CES_ADDR_LEC, {13'h0000, codes[i]}, 16'hFFFF);
    end
    wr16(`CES_ADDR_LEC, 16'h0005);
    rd16(`CES_ADDR_LEC, 16'h0007, 16'hFFFF);
    wr16(`CES_ADDR_LEC, 16'h0000);
    rd16(`CES_ADDR_LEC, 16'h0000, 16'hFFFF);
    ces_bus_node_inst.bit_cmp(1'b1, 1'b0, 1'b0);
    rd16(`CES_ADDR_LEC, 16'h0004, 16'hFFFF);
    ces_bus_node_inst.bit_cmp(1'b0, 1'b1, 1'b0);
    rd16(`CES_ADDR_LEC, 16'h0005, 16'hFFFF);
    ces_bus_node_inst.bit_cmp(1'b1, 1'b0, 1'b1);
    rd16(`CES_ADDR_LEC, 16'h0005, 16'hFFFF);
    init_mode <= 1'b1;
    rd16(`CES_ADDR_LEC, 16'h0005, 16'hFFFF);
    init_mode <= 1'b0;
    cnt(0, 12); chk_cnt();
    cnt(0, 4); chk_cnt();
    cnt(1, 1); chk_cnt();
    cnt(3, 16); chk_cnt();
    cnt(4, 1); chk_cnt();
    cnt(0, 17); chk_cnt();
    cnt(1, 3); chk_cnt();
    cnt(5, 1); chk_cnt();
    repeat (3) begin
      seed = lfsr(seed);
      cnt(2, seed[6:0]); chk_cnt();
      cnt(5, 1);
    end
    cnt(0, 5); cnt(2, 3);
    wr16(`CES_ADDR_CTRL, 16'h0001);
    chk_cnt();
    init_mode <= 1'b1;
    wr16(`CES_ADDR_CTRL, 16'h0001);
    {tx_error_count, rx_error_count} = 64'h0;
    chk_cnt();
    rd16(`CES_ADDR_CTRL, 16'h0000, 16'hFFFF);
    init_mode <= 1'b0;
    repeat (10) begin
      seed = lfsr(seed);
      w[15:8] = {2'b00, seed[5:0]};
      seed = lfsr(seed);
      w[7:0] = {2'b00, seed[5:0]};
      wr16(`CES_ADDR_IE, w);
      ie = (ie & ~(w[5:0] & ~w[13:8])) | (w[13:8] & ~w[5:0]);
      rd16(`CES_ADDR_IE, {10'h000, ie}, 16'hFFFF);
    end
    wr16(`CES_ADDR_IE, 16'h003F);
    wr16(`CES_ADDR_INTS, 16'h003F);
    rd16(`CES_ADDR_INTS, 16'h0000, 16'hFFFF);
    ces_bus_node_inst.irq(6'h21);
    rd16(`CES_ADDR_INTS, 16'h0021, 16'hFFFF);
    chk_irq(1'b0);
    wr16(`CES_ADDR_IE, 16'h0100);
    chk_irq(1'b1);
    wr16(`CES_ADDR_INTS, 16'h0001);
    chk_irq(1'b0);
    wr16(`CES_ADDR_IE, 16'h2000);
    chk_irq(1'b1);
    wr16(`CES_ADDR_INTS, 16'h0020);
    chk_irq(1'b0);
    wr16(`CES_ADDR_IE, 16'h0100);
    ces_bus_node_inst.irq(6'h01);
    chk_irq(1'b1);
    wr16(`CES_ADDR_INTS, 16'h0001);
    chk_irq(1'b0);
    repeat (3) @(posedge clk_sys_i);
    give_verdict();
  end
endmodule
`default_nettype wire
